// [bench/housekeeping_adc_monitor.sv]
// assertion checker bound to housekeeping adc control
module housekeeping_adc_monitor #(
   parameter MINUTE_TICKS = 20
) (
   input wire clk_sys,
   input wire reset,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire [7:0] sfr_rdata,
   input wire lock_loss_reset,
   input wire conv_req,
   input wire [1:0] conv_sel,
   input wire conv_ack,
   input wire conv_done,
   input wire adc_irq,
   input wire low_battery_set,
   input wire clock_lock_fault
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   req_hold_a: assert property (conv_req && !conv_ack
      |=> conv_req && $stable(conv_sel)) else $error("request not held");
   req_drop_a: assert property (conv_req && conv_ack |=> !conv_req)
      else $error("request not dropped");
   irq_cause_a: assert property (adc_irq
      |-> $past(conv_done) && !$past(conv_req)) else $error("irq uncaused");
   irq_pulse_a: assert property (adc_irq |=> !adc_irq)
      else $error("irq too long");
   low_irq_a: assert property (low_battery_set |-> adc_irq)
      else $error("low flag without irq");
   fault_set_a: assert property (lock_loss_reset |=> clock_lock_fault)
      else $error("fault not set");
   fault_ack_a: assert property (sfr_wr && sfr_addr == 8'hD8
      && sfr_wdata[7] && !lock_loss_reset |=> !clock_lock_fault)
      else $error("fault not cleared");
   start_read_a: assert property (sfr_addr == 8'hD8
      |-> sfr_rdata[7:3] == 5'h00) else $error("start bits nonzero");
   delta_read_a: assert property (sfr_addr == 8'hF3
      |-> sfr_rdata[7:6] == 2'h0) else $error("delta bits nonzero");
   cover property (conv_req && conv_ack);
   cover property (low_battery_set);
   cover property (adc_irq && !low_battery_set);
endmodule
bind housekeeping_adc_control housekeeping_adc_monitor
   #(.MINUTE_TICKS(MINUTE_TICKS)) i_mon (.clk_sys(clk_sys), .reset(reset),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
   .sfr_rdata(sfr_rdata), .lock_loss_reset(lock_loss_reset),
   .conv_req(conv_req), .conv_sel(conv_sel), .conv_ack(conv_ack),
   .conv_done(conv_done), .adc_irq(adc_irq),
   .low_battery_set(low_battery_set), .clock_lock_fault(clock_lock_fault));

// [bench/tb.sv]
// self-checking bench for housekeeping adc control
module tb;
timeunit 1ns;
timeprecision 1ns;
logic clk_sys, reset, sfr_wr, battery_power_state, sleep_power_state;
logic lock_loss_reset, conv_ack, conv_done, e;
logic [7:0] sfr_addr, sfr_wdata, conv_result, last, r, thr;
wire [7:0] sfr_rdata;
wire conv_req, adc_irq, low_battery_set, clock_lock_fault;
wire [1:0] conv_sel;
integer fail_count = 0, comparisons = 0, cycles = 0, seed = 67557;
integer i, c, d, k;
logic [7:0] regs [4] = '{8'hD8, 8'hF3, 8'hF9, 8'hFA};
housekeeping_adc_control #(.MINUTE_TICKS(20)) i_housekeeping_adc_control (
   .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
   .battery_power_state(battery_power_state),
   .sleep_power_state(sleep_power_state), .lock_loss_reset(lock_loss_reset),
   .conv_req(conv_req), .conv_sel(conv_sel), .conv_ack(conv_ack),
   .conv_done(conv_done), .conv_result(conv_result), .adc_irq(adc_irq),
   .low_battery_set(low_battery_set), .clock_lock_fault(clock_lock_fault));
always #25 clk_sys = ~clk_sys;
task check(input [7:0] seen, input [7:0] exp);
   comparisons++;
   if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
   end
endtask
task print_verdict;
   if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish;
endtask
task wr(input [7:0] a, input [7:0] v);
   sfr_addr = a;
   sfr_wdata = v;
   sfr_wr = 1'b1;
   @(negedge clk_sys);
   sfr_wr = 1'b0;
   @(negedge clk_sys);
endtask
task rd(input [7:0] a, input [7:0] x);
   sfr_addr = a;
   #1 check(sfr_rdata, x);
   @(negedge clk_sys);
endtask
// waits for a request, accepts it, returns a result, checks irq flags
task serve(input [1:0] sel, input [7:0] res, input [1:0] x);
   integer n;
   n = 0;
   while (conv_req !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
   end
   check({conv_req, conv_sel}, {1'b1, sel});
   conv_ack = 1'b1;
   @(negedge clk_sys);
   conv_ack = 1'b0;
   @(negedge clk_sys);
   conv_done = 1'b1;
   conv_result = res;
   @(negedge clk_sys);
   conv_done = 1'b0;
   check({adc_irq, low_battery_set}, x);
endtask
always @(posedge clk_sys) begin
   cycles++;
   if (cycles == 20000) begin
      fail_count++;
      print_verdict;
   end
end
initial begin
   clk_sys = 0; reset = 1; sfr_wr = 0; sfr_addr = 0; sfr_wdata = 0;
   battery_power_state = 0; sleep_power_state = 0; lock_loss_reset = 1;
   conv_ack = 0; conv_done = 0; conv_result = 0;
   repeat (20) @(negedge clk_sys);
   lock_loss_reset = 1'b0;
   reset = 1'b0;
   check(clock_lock_fault, 8'h01);
   foreach (regs[k]) rd(regs[k], 8'h00);
   wr(8'hD8, 8'h80);
   check(clock_lock_fault, 8'h00);
   // bg blocked in battery mode, strobe stored as written
   battery_power_state = 1'b1;
   r = ($random(seed) & 8'h3F) | 8'h15;
   wr(8'hF9, r);
   rd(8'hF9, r);
   repeat (60) @(negedge clk_sys);
   check(conv_req, 8'h00);
   wr(8'hF9, 8'h00);
   battery_power_state = 1'b0;
   r = $random(seed);
   wr(8'hF3, r);
   rd(8'hF3, r & 8'h3F);
   wr(8'hA0, 8'hFF);
   rd(8'hA0, 8'h00);
   last = 8'h80;
   wr(8'hD8, 8'h02);
   serve(2'h1, last, 2'b10);
   rd(8'hD8, 8'h00);
   wr(8'hF9, 8'h03);
   for (c = 0; c < 8; c++) begin
      wr(8'hF3, c << 3);
      for (i = 0; i < 2; i++) begin
         d = $random(seed) % 8;
         r = last + d;
         e = c == 7 || (c != 0 && (d < 0 ? -d : d) > c);
         serve(2'h1, r, {e, 1'b0});
         if (e) last = r;
         rd(8'hD7, last);
      end
   end
   thr = $random(seed);
   wr(8'hFA, thr);
   wr(8'hF9, 8'h0C);
   for (i = 0; i < 4; i++) begin
      r = i == 0 ? thr - 8'h01 : i == 1 ? thr : $random(seed);
      serve(2'h2, r, {2{r < thr}});
      rd(8'hDF, r);
   end
   wr(8'hF9, 8'h00);
   wr(8'hD8, 8'h07);
   rd(8'hD8, 8'h07);
   for (c = 0; c < 3; c++) serve(c, $random(seed), 2'b10);
   rd(8'hD8, 8'h00);
   // sleep: supply and temp still run, battery skipped
   sleep_power_state = 1'b1;
   wr(8'hF3, 8'h3F);
   wr(8'hF9, 8'h3F);
   r = $random(seed);
   serve(2'h0, r, 2'b10);
   rd(8'hEF, r);
   serve(2'h1, $random(seed), 2'b10);
   wr(8'hF9, 8'h00);
   repeat (30) @(negedge clk_sys);
   check(conv_req, 8'h00);
   // lock loss during an acknowledge: set wins
   lock_loss_reset = 1'b1;
   wr(8'hD8, 8'h80);
   check(clock_lock_fault, 8'h01);
   lock_loss_reset = 1'b0;
   wr(8'hD8, 8'h80);
   check(clock_lock_fault, 8'h00);
   print_verdict;
end
endmodule

// [rtl/housekeeping_adc_control.v]
// housekeeping adc scheduling and register logic
`include "housekeeping_adc_map.vh"
module housekeeping_adc_control #(
   parameter MINUTE_TICKS = `MINUTE_CYCLES
) (
   input wire clk_sys,
   input wire reset,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   output reg [7:0] sfr_rdata,
   input wire battery_power_state,
   input wire sleep_power_state,
   input wire lock_loss_reset,
   output reg conv_req,
   output reg [1:0] conv_sel,
   input wire conv_ack,
   input wire conv_done,
   input wire [7:0] conv_result,
   output reg adc_irq,
   output reg low_battery_set,
   output reg clock_lock_fault
);
   localparam IDLE = 1'b0;
   localparam BUSY = 1'b1;
   reg [7:0] strobe_reg;
   reg [7:0] delta_reg;
   reg [7:0] thresh_reg;
   reg [7:0] temp_reg;
   reg [7:0] batt_reg;
   reg [7:0] supply_reg;
   reg [7:0] temp_last_reg;
   reg [7:0] supply_last_reg;
   reg [2:0] go_reg;
   reg [2:0] bg_reg;
   reg [2:0] active_single_reg;
   reg active_bg_reg;
   reg state_reg;
   reg [31:0] tick_reg;
   reg [4:0] minute_reg;
   wire minute_tick = (tick_reg == MINUTE_TICKS - 1);
   wire bg_allowed = ~battery_power_state;
   wire wr_start = sfr_wr && (sfr_addr == `ADDR_START_CTRL);
   function period_hit;
      input [1:0] code;
      input [4:0] minutes;
      input long;
      begin
         case (code)
            2'h1: period_hit = long ? (minutes[3:0] == 4'h0)
                                    : (minutes[2:0] == 3'h0);
            2'h2: period_hit = long ? (minutes[1:0] == 2'h0)
                                    : (minutes[0] == 1'b0);
            2'h3: period_hit = 1'b1;
            default: period_hit = 1'b0;
         endcase
      end
   endfunction
   function delta_hit;
      input [2:0] code;
      input [7:0] a;
      input [7:0] b;
      reg [7:0] d;
      begin
         d = (a > b) ? a - b : b - a;
         if (code == `DELTA_NONE)
            delta_hit = 1'b0;
         else if (code == `DELTA_EVERY)
            delta_hit = 1'b1;
         else
            delta_hit = (d > {5'h00, code});
      end
   endfunction
   wire [2:0] pend = go_reg | bg_reg;
   wire [1:0] pick = pend[`BIT_SUPPLY_GO] ? `CONV_SUPPLY :
      (pend[`BIT_TEMP_GO] ? `CONV_TEMP : `CONV_BATT);
   wire [2:0] pick_mask = pend[`BIT_SUPPLY_GO] ? 3'h4 :
      (pend[`BIT_TEMP_GO] ? 3'h2 : 3'h1);
   // request bit of the conversion in flight
   wire [2:0] sel_mask = (conv_sel == `CONV_SUPPLY) ? 3'h4 :
      ((conv_sel == `CONV_TEMP) ? 3'h2 : 3'h1);
   wire bg_supply = minute_tick && bg_allowed &&
      period_hit(strobe_reg[5:4], minute_reg, 1'b0);
   wire bg_temp = minute_tick && bg_allowed &&
      period_hit(strobe_reg[1:0], minute_reg, 1'b0);
   wire bg_batt = minute_tick && bg_allowed && !sleep_power_state &&
      period_hit(strobe_reg[3:2], minute_reg, 1'b1);
   wire [2:0] bg_set = {bg_supply, bg_temp, bg_batt};
   wire temp_irq = active_single_reg[`BIT_TEMP_GO] ||
      delta_hit(delta_reg[5:3], conv_result, temp_last_reg);
   wire supply_irq = active_single_reg[`BIT_SUPPLY_GO] ||
      delta_hit(delta_reg[2:0], conv_result, supply_last_reg);
   wire batt_low = conv_result < thresh_reg;
   always @* begin
      case (sfr_addr)
         `ADDR_TEMP_RESULT: sfr_rdata = temp_reg;
         `ADDR_START_CTRL: sfr_rdata = {5'h00, go_reg};
         `ADDR_BATT_RESULT: sfr_rdata = batt_reg;
         `ADDR_SUPPLY_RESULT: sfr_rdata = supply_reg;
         `ADDR_DELTA_CFG: sfr_rdata = {2'h0, delta_reg[5:0]};
         `ADDR_STROBE_PERIOD: sfr_rdata = strobe_reg;
         `ADDR_BATT_THRESH: sfr_rdata = thresh_reg;
         default: sfr_rdata = `RESET_BYTE;
      endcase
   end
   always @(posedge clk_sys) begin
      if (reset) begin
         tick_reg <= 32'h0;
         minute_reg <= 5'h00;
      end else if (minute_tick) begin
         tick_reg <= 32'h0;
         minute_reg <= minute_reg + 5'h01;
      end else begin
         tick_reg <= tick_reg + 32'h1;
      end
   end
   always @(posedge clk_sys) begin
      if (reset) begin
         strobe_reg <= `RESET_BYTE;
         delta_reg <= `RESET_BYTE;
         thresh_reg <= `RESET_BYTE;
         temp_reg <= `RESET_BYTE;
         batt_reg <= `RESET_BYTE;
         supply_reg <= `RESET_BYTE;
         temp_last_reg <= `RESET_BYTE;
         supply_last_reg <= `RESET_BYTE;
         go_reg <= 3'h0;
         bg_reg <= 3'h0;
         active_single_reg <= 3'h0;
         active_bg_reg <= 1'b0;
         state_reg <= IDLE;
         conv_req <= 1'b0;
         conv_sel <= `CONV_SUPPLY;
         adc_irq <= 1'b0;
         low_battery_set <= 1'b0;
      end else begin
         adc_irq <= 1'b0;
         low_battery_set <= 1'b0;
         // reserved strobe bits stored as written
         if (sfr_wr && sfr_addr == `ADDR_STROBE_PERIOD)
            strobe_reg <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ADDR_DELTA_CFG)
            delta_reg <= {2'h0, sfr_wdata[5:0]};
         if (sfr_wr && sfr_addr == `ADDR_BATT_THRESH)
            thresh_reg <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ADDR_SUPPLY_RESULT)
            supply_reg <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ADDR_BATT_RESULT)
            batt_reg <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ADDR_TEMP_RESULT)
            temp_reg <= sfr_wdata;
         bg_reg <= bg_reg | bg_set;
         if (wr_start)
            go_reg <= go_reg | sfr_wdata[2:0];
         case (state_reg)
            IDLE: begin
               // fixed priority, one at a time
               if (pend != 3'h0) begin
                  conv_req <= 1'b1;
                  conv_sel <= pick;
                  state_reg <= BUSY;
                  active_single_reg <= go_reg & pick_mask;
                  active_bg_reg <= 1'b0;
               end
            end
            BUSY: begin
               if (conv_req && conv_ack) begin
                  conv_req <= 1'b0;
                  go_reg <= (go_reg | (wr_start ? sfr_wdata[2:0] : 3'h0))
                     & ~active_single_reg;
                  active_bg_reg <= ((bg_reg & sel_mask) != 3'h0);
                  // new background requests survive the clear
                  bg_reg <= (bg_reg & ~sel_mask) | bg_set;
               end
               if (!conv_req && conv_done) begin
                  state_reg <= IDLE;
                  case (conv_sel)
                     `CONV_SUPPLY: begin
                        if (supply_irq) begin
                           supply_reg <= conv_result;
                           supply_last_reg <= conv_result;
                           adc_irq <= 1'b1;
                        end
                     end
                     `CONV_TEMP: begin
                        if (temp_irq) begin
                           temp_reg <= conv_result;
                           temp_last_reg <= conv_result;
                           adc_irq <= 1'b1;
                        end
                     end
                     default: begin
                        batt_reg <= conv_result;
                        if (batt_low || active_single_reg[`BIT_BATT_GO])
                           adc_irq <= 1'b1;
                        if (batt_low && active_bg_reg)
                           low_battery_set <= 1'b1;
                     end
                  endcase
               end
            end
            default: state_reg <= IDLE;
         endcase
      end
   end
   always @(posedge clk_sys) begin
      // lock loss sets fault, wins over ack
      if (lock_loss_reset)
         clock_lock_fault <= 1'b1;
      else if (reset)
         clock_lock_fault <= 1'b0;
      else if (wr_start && sfr_wdata[`BIT_FAULT_ACK])
         clock_lock_fault <= 1'b0;
   end
endmodule

// [rtl/housekeeping_adc_map.vh]
// register map and timing constants for housekeeping adc control
// Function
// - supply interval field selects background supply rate
// - battery interval field selects background battery rate
// - temperature interval field selects background temperature rate
// - temperature delta field sets temperature interrupt threshold
// - supply delta field sets supply interrupt threshold
// - start bit 2 requests supply conversion, self-clears
// - start bit 1 requests temperature conversion, self-clears
// - start bit 0 requests battery conversion, self-clears
// - start bit 7 clears clock lock fault
// - lock-loss reset sets clock lock fault
// - battery result below threshold raises interrupt
// - measurements may continue in low-power states
// - temperature delta measured from last interrupting result
// - temperature result loads only on its interrupt (code also loads it on an sfr write to 8'hD7)
// - background low battery sets low battery flag
`ifndef HOUSEKEEPING_ADC_MAP_VH
`define HOUSEKEEPING_ADC_MAP_VH
`define ADDR_TEMP_RESULT 8'hD7
`define ADDR_START_CTRL 8'hD8
`define ADDR_BATT_RESULT 8'hDF
`define ADDR_SUPPLY_RESULT 8'hEF
`define ADDR_DELTA_CFG 8'hF3
`define ADDR_STROBE_PERIOD 8'hF9
`define ADDR_BATT_THRESH 8'hFA
`define BIT_SUPPLY_GO 2
`define BIT_TEMP_GO 1
`define BIT_BATT_GO 0
`define BIT_FAULT_ACK 7
`define BIT_LOW_BATT 2
`define BIT_CLOCK_FAULT 4
`define DELTA_NONE 3'h0
`define DELTA_EVERY 3'h7
`define RESET_BYTE 8'h00
`define MINUTE_S 60
`define CLK_HZ 20000000
`define MINUTE_CYCLES (`MINUTE_S * `CLK_HZ)
`define CONV_SUPPLY 2'h0
`define CONV_TEMP 2'h1
`define CONV_BATT 2'h2
`endif
